//--- logic/tcba_pkg.sv
// Package for the 16-bit timer counter core and its byte access path
package tcba_pkg;

  // ----------------------------------------------------------------
  // Byte access addresses
  // ----------------------------------------------------------------
  localparam logic [2:0] TCBA_ADDR_CNT_LOW = 3'h0;
  localparam logic [2:0] TCBA_ADDR_CNT_HIGH = 3'h1;
  localparam logic [2:0] TCBA_ADDR_CMPA_LOW = 3'h2;
  localparam logic [2:0] TCBA_ADDR_CMPA_HIGH = 3'h3;
  localparam logic [2:0] TCBA_ADDR_CMPB_LOW = 3'h4;
  localparam logic [2:0] TCBA_ADDR_CMPB_HIGH = 3'h5;
  localparam logic [2:0] TCBA_ADDR_CAP_LOW = 3'h6;
  localparam logic [2:0] TCBA_ADDR_CAP_HIGH = 3'h7;

  // ----------------------------------------------------------------
  // Field layouts and reset values
  // ----------------------------------------------------------------
  localparam int TCBA_CTLA_WGM_LSB = 0;
  localparam int TCBA_CTLB_WGM_LSB = 3;
  localparam int TCBA_CTLB_CS_LSB = 0;
  localparam logic [15:0] TCBA_CNT_RESET = 16'h0000;
  localparam logic [7:0] TCBA_LATCH_RESET = 8'h00;
  localparam logic [7:0] TCBA_CTL_RESET = 8'h00;
  localparam logic [2:0] TCBA_CS_NONE = 3'h0;

  // ----------------------------------------------------------------
  // Fixed ceiling constants and extreme values
  // ----------------------------------------------------------------
  localparam logic [15:0] TCBA_TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TCBA_TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TCBA_TOP_10BIT = 16'h03ff;
  localparam logic [15:0] TCBA_MAX = 16'hffff;
  localparam logic [15:0] TCBA_FLOOR = 16'h0000;

  // Ceiling source chosen by the waveform mode
  typedef enum logic [2:0] {
    TCBA_TOP_MAX,
    TCBA_TOP_FIX8,
    TCBA_TOP_FIX9,
    TCBA_TOP_FIX10,
    TCBA_TOP_CMPA,
    TCBA_TOP_CAP
  } tcba_top_sel_t;

  // Decode of the four-bit waveform mode field
  function automatic tcba_top_sel_t tcba_top_sel(input logic [3:0] wgm);
    case (wgm)
      4'h1, 4'h5: tcba_top_sel = TCBA_TOP_FIX8;
      4'h2, 4'h6: tcba_top_sel = TCBA_TOP_FIX9;
      4'h3, 4'h7: tcba_top_sel = TCBA_TOP_FIX10;
      4'h4, 4'h9, 4'hb, 4'hf: tcba_top_sel = TCBA_TOP_CMPA;
      4'h8, 4'ha, 4'hc, 4'he: tcba_top_sel = TCBA_TOP_CAP;
      default: tcba_top_sel = TCBA_TOP_MAX;
    endcase
  endfunction

  // Modes that turn at the ceiling and count back down
  function automatic logic tcba_dual_slope(input logic [3:0] wgm);
    case (wgm)
      4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb: tcba_dual_slope = 1'b1;
      default: tcba_dual_slope = 1'b0;
    endcase
  endfunction

endpackage

//--- logic/tcba_counter.sv
// Bidirectional 16-bit count unit with clear, load and extreme flags
`timescale 1ns/100ps
`default_nettype none
module tcba_counter
  import tcba_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic count_en,
  input wire logic dir_down,
  input wire logic clear,
  input wire logic load,
  input wire logic [15:0] load_value,
  input wire logic [15:0] top_value,
  output logic [15:0] count,
  output logic at_top,
  output logic at_floor
);
  logic [15:0] count_q;
  logic [15:0] count_d;

  // ----------------------------------------------------------------
  // Next count
  // ----------------------------------------------------------------
  // CPU load beats any tick action so software always sees its value
  always_comb begin
    count_d = count_q;
    if (load) begin
      count_d = load_value;
    end else if (tick) begin
      if (clear) begin
        count_d = TCBA_FLOOR;
      end else if (count_en) begin
        count_d = dir_down ? count_q - 16'h0001 : count_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q <= TCBA_CNT_RESET;
    end else begin
      count_q <= count_d;
    end
  end

  assign count = count_q;
  assign at_top = (count_q == top_value);
  assign at_floor = (count_q == TCBA_FLOOR);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_load_wins: assert property (@(posedge clk) disable iff (rst)
    load |=> count_q == $past(load_value)) else $error("load lost");
  a_idle_hold: assert property (@(posedge clk) disable iff (rst)
    !load && !tick |=> $stable(count_q)) else $error("count moved without tick");
  a_step_one: assert property (@(posedge clk) disable iff (rst)
    !load && tick && !clear && count_en && !dir_down |=> count_q == $past(count_q) + 16'h0001)
    else $error("bad up step");
endmodule
`default_nettype wire

//--- logic/tcba_timer.sv
// Top of the 16-bit timer core with shared high-byte latch access
//
// Overview of operation
// - Four 16-bit registers, byte accessed
// - One shared 8-bit high-byte latch
// - Low write loads latch and low together
// - Counter and capture low reads copy high byte to latch
// - Counter high location is the latch
// - Compare reads bypass the latch
// - Three-bit field selects timer clock
// - Step by one, clear to zero
// - Ceiling and floor indications
// - Tick clears, increments or decrements
// - Field zero stops the counter
// - Counter accessible with or without ticks
// - CPU write beats clear or count
// - Four-bit waveform field sets sequence
// - Overflow flag set per waveform mode
// - Ceiling fixed, compare A or capture
// - Capture writable only when it's ceiling
`timescale 1ns/100ps
`default_nettype none
module tcba_timer
  import tcba_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic [7:0] timer_control_a,
  input wire logic [7:0] timer_control_b,
  input wire logic [7:1] source_tick,
  input wire logic [15:0] capture_in,
  input wire logic capture_event,
  input wire logic overflow_clear,
  output logic overflow_flag,
  output logic [15:0] timer_count,
  output logic [15:0] compare_value_a,
  output logic [15:0] compare_value_b,
  output logic [15:0] capture_value,
  output logic count_ceiling,
  output logic count_floor,
  output logic timer_tick
);
  logic [7:0] latch_q, latch_d;
  logic [15:0] cmpa_q, cmpa_d, cmpb_q, cmpb_d, cap_q, cap_d;
  logic [7:0] rdata_q, rdata_d;
  logic ovf_q, ovf_d;
  logic down_q, down_d;
  logic [2:0] clock_select_field;
  logic [3:0] waveform_mode_field;
  tcba_top_sel_t top_sel;
  logic [15:0] top_value;
  logic cnt_load, cnt_clear, cnt_down, dual;
  logic [15:0] cnt;
  logic at_top, at_floor;

  // ----------------------------------------------------------------
  // Control field decode
  // ----------------------------------------------------------------
  assign clock_select_field = timer_control_b[TCBA_CTLB_CS_LSB +: 3];
  assign waveform_mode_field = {timer_control_b[TCBA_CTLB_WGM_LSB +: 2],
                                timer_control_a[TCBA_CTLA_WGM_LSB +: 2]};
  assign top_sel = tcba_top_sel(waveform_mode_field);
  assign dual = tcba_dual_slope(waveform_mode_field);

  // Pick one prescaled or external source; select zero gives none
  assign timer_tick = (clock_select_field == TCBA_CS_NONE) ? 1'b0
                    : source_tick[clock_select_field];

  // Ceiling value per mode
  always_comb begin
    case (top_sel)
      TCBA_TOP_FIX8: top_value = TCBA_TOP_8BIT;
      TCBA_TOP_FIX9: top_value = TCBA_TOP_9BIT;
      TCBA_TOP_FIX10: top_value = TCBA_TOP_10BIT;
      TCBA_TOP_CMPA: top_value = cmpa_q;
      TCBA_TOP_CAP: top_value = cap_q;
      default: top_value = TCBA_MAX;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequence control
  // ----------------------------------------------------------------
  // Single-slope modes wrap to zero at the ceiling; dual-slope turn round
  always_comb begin
    down_d = down_q;
    cnt_clear = 1'b0;
    if (!dual) begin
      down_d = 1'b0;
      cnt_clear = at_top;
    end else if (timer_tick) begin
      if (at_top && !down_q) begin
        down_d = 1'b1;
      end else if (at_floor && down_q) begin
        down_d = 1'b0;
      end
    end
  end
  assign cnt_down = dual && (down_q || (at_top && !down_q)) && !(at_floor && down_q);

  // Overflow: single-slope at ceiling wrap, dual-slope at floor; set wins
  always_comb begin
    ovf_d = ovf_q;
    if (overflow_clear) begin
      ovf_d = 1'b0;
    end
    if (timer_tick && !cnt_load && (dual ? (at_floor && down_q) : at_top)) begin
      ovf_d = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Byte access path
  // ----------------------------------------------------------------
  assign cnt_load = wr_en && (addr == TCBA_ADDR_CNT_LOW);

  always_comb begin
    latch_d = latch_q;
    cmpa_d = cmpa_q;
    cmpb_d = cmpb_q;
    cap_d = cap_q;
    rdata_d = rdata_q;
    if (wr_en) begin
      case (addr)
        TCBA_ADDR_CNT_HIGH, TCBA_ADDR_CMPA_HIGH, TCBA_ADDR_CMPB_HIGH,
        TCBA_ADDR_CAP_HIGH: latch_d = wdata;
        TCBA_ADDR_CMPA_LOW: cmpa_d = {latch_q, wdata};
        TCBA_ADDR_CMPB_LOW: cmpb_d = {latch_q, wdata};
        TCBA_ADDR_CAP_LOW: begin
          if (top_sel == TCBA_TOP_CAP) begin
            cap_d = {latch_q, wdata};
          end
        end
        default: ;
      endcase
    end else if (rd_en) begin
      case (addr)
        TCBA_ADDR_CNT_LOW: begin
          rdata_d = cnt[7:0];
          latch_d = cnt[15:8];
        end
        TCBA_ADDR_CAP_LOW: begin
          rdata_d = cap_q[7:0];
          latch_d = cap_q[15:8];
        end
        TCBA_ADDR_CMPA_LOW: rdata_d = cmpa_q[7:0];
        TCBA_ADDR_CMPA_HIGH: rdata_d = cmpa_q[15:8];
        TCBA_ADDR_CMPB_LOW: rdata_d = cmpb_q[7:0];
        TCBA_ADDR_CMPB_HIGH: rdata_d = cmpb_q[15:8];
        default: rdata_d = latch_q;
      endcase
    end
    // Capture hardware only loads when capture is not the ceiling
    if (capture_event && top_sel != TCBA_TOP_CAP &&
        !(wr_en && addr == TCBA_ADDR_CAP_LOW)) begin
      cap_d = capture_in;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      latch_q <= TCBA_LATCH_RESET;
      cmpa_q <= TCBA_CNT_RESET;
      cmpb_q <= TCBA_CNT_RESET;
      cap_q <= TCBA_CNT_RESET;
      rdata_q <= TCBA_LATCH_RESET;
      ovf_q <= 1'b0;
      down_q <= 1'b0;
    end else begin
      latch_q <= latch_d;
      cmpa_q <= cmpa_d;
      cmpb_q <= cmpb_d;
      cap_q <= cap_d;
      rdata_q <= rdata_d;
      ovf_q <= ovf_d;
      down_q <= down_d;
    end
  end

  // ----------------------------------------------------------------
  // Count unit
  // ----------------------------------------------------------------
  tcba_counter u_counter (
    .clk(clk),
    .rst(rst),
    .tick(timer_tick),
    .count_en(1'b1),
    .dir_down(cnt_down),
    .clear(cnt_clear),
    .load(cnt_load),
    .load_value({latch_q, wdata}),
    .top_value(top_value),
    .count(cnt),
    .at_top(at_top),
    .at_floor(at_floor)
  );

  assign rdata = rdata_q;
  assign overflow_flag = ovf_q;
  assign timer_count = cnt;
  assign compare_value_a = cmpa_q;
  assign compare_value_b = cmpb_q;
  assign capture_value = cap_q;
  assign count_ceiling = at_top;
  assign count_floor = at_floor;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_low_read_latch: assert property (@(posedge clk) disable iff (rst)
    rd_en && !wr_en && addr == TCBA_ADDR_CNT_LOW |=> latch_q == $past(cnt[15:8]))
    else $error("latch not loaded on low read");
  a_cmp_read_keep: assert property (@(posedge clk) disable iff (rst)
    rd_en && !wr_en && addr[2:1] inside {2'h1, 2'h2} && !capture_event |=> $stable(latch_q))
    else $error("compare read touched latch");
  a_cmpa_write: assert property (@(posedge clk) disable iff (rst)
    wr_en && addr == TCBA_ADDR_CMPA_LOW |=> cmpa_q == {$past(latch_q), $past(wdata)})
    else $error("compare A not loaded");
  a_high_read_latch: assert property (@(posedge clk) disable iff (rst)
    rd_en && !wr_en && addr == TCBA_ADDR_CNT_HIGH |=> rdata_q == $past(latch_q))
    else $error("high read bypassed latch");
  a_stop_hold: assert property (@(posedge clk) disable iff (rst)
    clock_select_field == TCBA_CS_NONE && !wr_en ##1 clock_select_field == TCBA_CS_NONE
    |-> $stable(cnt)) else $error("stopped counter moved");
  a_cap_guard: assert property (@(posedge clk) disable iff (rst)
    wr_en && addr == TCBA_ADDR_CAP_LOW && top_sel != TCBA_TOP_CAP && !capture_event
    |=> $stable(cap_q)) else $error("capture written outside mode");
  a_ovf_set: assert property (@(posedge clk) disable iff (rst)
    timer_tick && !cnt_load && !dual && at_top |=> ovf_q && cnt == TCBA_FLOOR)
    else $error("overflow not raised at wrap");
  a_cnt_write: assert property (@(posedge clk) disable iff (rst)
    cnt_load |=> cnt == {$past(latch_q), $past(wdata)}) else $error("counter write lost");
  c_wrap: cover property (@(posedge clk) disable iff (rst) timer_tick && at_top && !dual);
  c_turn: cover property (@(posedge clk) disable iff (rst) timer_tick && at_top && dual);
  c_write_tick: cover property (@(posedge clk) disable iff (rst) cnt_load && timer_tick);
  c_read_pair: cover property (@(posedge clk) disable iff (rst)
    rd_en && addr == TCBA_ADDR_CNT_LOW ##1 rd_en && addr == TCBA_ADDR_CNT_HIGH);
endmodule
`default_nettype wire

//--- verif/tcba_cpu_model.sv
// CPU-side byte bus model for the timer core
`timescale 1ns/100ps
`default_nettype none
module tcba_cpu_model (
  input wire logic clk,
  input wire logic [7:0] rdata,
  output logic [2:0] addr,
  output logic [7:0] wdata,
  output logic wr_en,
  output logic rd_en
);
  // Idle bus at time zero
  initial begin
    addr = 3'h0;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end
  // One byte write; strobe spans exactly one taking edge
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    #10;
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(posedge clk);
    #10;
    wr_en = 1'b0;
    wdata = ~d; // Stale data never lingers on the bus
  endtask
  // One byte read; data is registered at the taking edge
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    #10;
    addr = a;
    rd_en = 1'b1;
    @(posedge clk);
    #10;
    rd_en = 1'b0;
    d = rdata;
  endtask
  // High first, low last; pairs never interleave
  task automatic wr16(input logic [2:0] lo, input logic [15:0] v);
    wr(lo + 3'h1, v[15:8]);
    wr(lo, v[7:0]);
  endtask
endmodule
`default_nettype wire

//--- verif/tcba_timer_tb.sv
// Self-checking bench for the timer core and byte access path
`timescale 1ns/100ps
`default_nettype none
module tcba_timer_tb;
  import tcba_pkg::*;
  logic clk, rst, wr_en, rd_en, cap_ev, ovf_clr, ovf, ceil, flr, tick;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, ctl_a, ctl_b, b;
  logic [7:1] src;
  logic [15:0] cap_in, cnt, cmpa, cmpb, cap, r, r2;
  int fail_count, checks_done, cyc, m_cnt, m_dir, m_ovf, m_cmpa, m_cap, mode, t;

  tcba_timer i_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .timer_control_a(ctl_a), .timer_control_b(ctl_b), .source_tick(src),
    .capture_in(cap_in), .capture_event(cap_ev), .overflow_clear(ovf_clr), .overflow_flag(ovf),
    .timer_count(cnt), .compare_value_a(cmpa), .compare_value_b(cmpb), .capture_value(cap),
    .count_ceiling(ceil), .count_floor(flr), .timer_tick(tick));
  tcba_cpu_model cpu (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en));

  // 10 MHz system clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Hang guard: far above the roughly 1,300 cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      fail_count++;
      final_report();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Ceiling per waveform mode, from the model's own register copies
  function automatic int top_of(input int m);
    case (m)
      1, 5: return 'hff;
      2, 6: return 'h1ff;
      3, 7: return 'h3ff;
      4, 9, 11, 15: return m_cmpa;
      8, 10, 12, 14: return m_cap;
      default: return 'hffff;
    endcase
  endfunction
  // Reference step: single slope wraps at the ceiling, dual slope turns
  task automatic step();
    int top;
    top = top_of(mode);
    if (!(mode inside {1, 2, 3, 8, 9, 10, 11})) begin
      m_ovf = (m_cnt == top) ? 1 : m_ovf;
      m_cnt = (m_cnt == top) ? 0 : m_cnt + 1;
    end else if (m_dir == 0) begin
      m_dir = (m_cnt == top) ? 1 : 0;
      m_cnt = (m_cnt == top) ? m_cnt - 1 : m_cnt + 1;
    end else begin
      m_ovf = (m_cnt == 0) ? 1 : m_ovf;
      m_dir = (m_cnt == 0) ? 0 : 1;
      m_cnt = (m_cnt == 0) ? 1 : m_cnt - 1;
    end
  endtask
  task automatic set_mode(input int m, input int cs);
    @(posedge clk);
    #10;
    mode = m;
    // Direction is only kept in dual-slope modes; the others force it up
    if (!(m inside {1, 2, 3, 8, 9, 10, 11})) m_dir = 0;
    ctl_a = {6'h00, m[1:0]};
    ctl_b = {3'h0, m[3:2], cs[2:0]};
  endtask
  // One source pulse; the count moves only if that source is selected
  task automatic pulse(input int s);
    chk(ceil, m_cnt == top_of(mode));
    chk(flr, m_cnt == 0);
    @(posedge clk);
    #10;
    src[s] = 1'b1;
    #1 chk(tick, ctl_b[2:0] == s);
    @(posedge clk);
    #10;
    src[s] = 1'b0;
    if (ctl_b[2:0] == s) step();
    chk(cnt, m_cnt[15:0]);
  endtask
  task automatic clr_ovf();
    chk(ovf, m_ovf[0]);
    @(posedge clk);
    #10;
    ovf_clr = 1'b1;
    @(posedge clk);
    #10;
    ovf_clr = 1'b0;
    m_ovf = 0;
    chk(ovf, 1'b0);
  endtask

  initial begin
    rst = 1'b1;
    cap_ev = 1'b0;
    ovf_clr = 1'b0;
    src = 7'h00;
    cap_in = 16'h0000;
    ctl_a = 8'h00;
    ctl_b = 8'h00;
    r = 16'hee87;
    {fail_count, checks_done, cyc, m_cnt, m_dir, m_ovf, m_cmpa, m_cap, mode} = '0;
    repeat (20) @(posedge clk);
    #10;
    rst = 1'b0;
    chk(cnt, 16'h0000);
    chk(ovf, 1'b0);
    chk(tick, 1'b0);
    // One high byte shared by counter and compare B
    r = nxt(r);
    r2 = nxt(nxt(r));
    cpu.wr(TCBA_ADDR_CNT_HIGH, r[15:8]);
    cpu.wr(TCBA_ADDR_CNT_LOW, r[7:0]);
    cpu.wr(TCBA_ADDR_CMPB_LOW, r2[7:0]);
    chk(cnt, r);
    chk(cmpb, {r[15:8], r2[7:0]});
    m_cnt = r;
    cpu.wr16(TCBA_ADDR_CMPA_LOW, r2);
    chk(cmpa, r2);
    // Counter low read fills the latch; compare reads must not touch it
    cpu.rd(TCBA_ADDR_CNT_LOW, b);
    chk(b, r[7:0]);
    cpu.rd(TCBA_ADDR_CMPA_LOW, b);
    chk(b, r2[7:0]);
    cpu.rd(TCBA_ADDR_CMPA_HIGH, b);
    chk(b, r2[15:8]);
    cpu.rd(TCBA_ADDR_CNT_HIGH, b);
    chk(b, r[15:8]);
    $display("latch test done");
    // Capture register is writable only when it is the ceiling
    cpu.wr16(TCBA_ADDR_CAP_LOW, r2);
    chk(cap, 16'h0000);
    set_mode(14, 0);
    cpu.wr16(TCBA_ADDR_CAP_LOW, 16'h0003);
    chk(cap, 16'h0003);
    m_cap = 3;
    cpu.rd(TCBA_ADDR_CAP_LOW, b);
    chk(b, 8'h03);
    cpu.rd(TCBA_ADDR_CAP_HIGH, b);
    chk(b, 8'h00);
    cpu.wr16(TCBA_ADDR_CMPA_LOW, 16'h0005);
    m_cmpa = 5;
    $display("capture write test done");
    // Every waveform mode: three ticks from two below the ceiling; modes 2, 3, 9 and 10 start downward
    for (int m = 0; m < 16; m++) begin
      set_mode(m, 1);
      t = top_of(m) - 2;
      cpu.wr16(TCBA_ADDR_CNT_LOW, t[15:0]);
      m_cnt = t;
      repeat (3) pulse(1);
      clr_ovf();
    end
    $display("mode sweep done");
    // Full dual-slope round trip through floor and ceiling
    set_mode(1, 1);
    cpu.wr16(TCBA_ADDR_CNT_LOW, 16'h0000);
    m_cnt = 0;
    repeat (520) pulse(1);
    pulse(3);
    clr_ovf();
    set_mode(1, 0);
    repeat (2) pulse(1);
    $display("dual slope test done");
    // CPU write lands on the same edge as a tick: the write wins
    set_mode(0, 1);
    cpu.wr(TCBA_ADDR_CNT_HIGH, r2[15:8]);
    fork
      cpu.wr(TCBA_ADDR_CNT_LOW, r2[7:0]);
      begin
        @(posedge clk);
        #10;
        src[1] = 1'b1;
        @(posedge clk);
        #10;
        src[1] = 1'b0;
      end
    join
    chk(cnt, r2);
    m_cnt = r2;
    // Capture event outside ceiling modes loads the capture register
    @(posedge clk);
    #10;
    cap_in = nxt(r2);
    cap_ev = 1'b1;
    @(posedge clk);
    #10;
    cap_ev = 1'b0;
    chk(cap, nxt(r2));
    $display("priority and capture test done");
    final_report();
  end
endmodule
`default_nettype wire
